// File: rtl/transfer_pkg.sv
// Constants and types shared by the transfer-instruction datapath
// ============================================================
// Behaviour
// [RULE1] First-immediate load drives its immediate field on the first bus phase.
// [RULE2] Second-immediate load drives its immediate field on the second bus phase.
// [RULE3] Any bus drive overlapping another source in that phase flags a conflict.
// [RULE4] Condition loads touch only data bus bit 15; other bits stay undriven.
// [RULE5] Condition-first load sets first-phase bit 15 when the flag is true.
// [RULE6] Condition-second load sets second-phase bit 15 when the flag is true.
// [RULE7] Index-first load drives the source index register on the first phase.
// [RULE8] Extra-first load drives the source extra register on the first phase.
// [RULE9] Conditional loads drive only when the flag is true, else nothing.
// [RULE10] Index-first store writes the first-phase value into the index file.
// [RULE11] Index-second store writes the second-phase value into the index file.
// [RULE12] Extra-first store writes the first-phase value into the extra file.
// [RULE13] Conditional stores write only when the flag is true.
// [RULE14] Stores and moves never report any error, including bus conflict.
// [RULE15] Moves use a private internal path and never drive the data bus.
// [RULE16] Index-to-index move reads at cycle start and writes by cycle end.
// [RULE17] Index-to-extra move copies index source into extra destination.
// [RULE18] Extra-to-index move copies extra source into index destination.
// [RULE19] Extra-to-extra move copies extra source into extra destination.
// [RULE20] Conditional moves copy only when the flag is true.
// [RULE21] Pause may join any instruction; no-operation stands alone.
// [RULE22] No-operation does nothing and takes one instruction cycle.
// [RULE23] Flag clears when extra register >= captured bus value, else sets.
// [RULE24] Combined load and move share one register number as source.
// [RULE25] Second-phase loads and stores mirror first-phase ones on phase two.
// [RULE26] True-condition loads drive bit 15 like plain condition loads.
// [RULE27] Opcode fields select the operation; unused bits read back as zero.
package transfer_pkg;

	// ============================================================
	// Widths
	localparam int DATA_W = 16;
	localparam int REG_AW = 7;
	localparam int WORD_W = 32;
	localparam int REG_DEPTH = 128;

	// ============================================================
	// Instruction word field positions (field 0 is the upper half)
	localparam int GROUP_HI = 31;
	localparam int GROUP_LO = 30;
	localparam int SRC_HI = 22;
	localparam int SRC_LO = 16;
	localparam int FIRST_CODE_HI = 15;
	localparam int FIRST_CODE_LO = 12;
	localparam int SECOND_CODE_HI = 11;
	localparam int SECOND_CODE_LO = 8;
	localparam int COND_POS = 7;
	localparam int SECOND_REG_HI = 6;
	localparam int SECOND_REG_LO = 0;
	localparam int IMM_HI = 15;
	localparam int IMM_LO = 0;

	// Bits that exist in the word; the rest always read as zero
	localparam logic [WORD_W-1:0] USED_MASK = 32'hCE7F_FFFF;

	// ============================================================
	// Opcode values
	localparam logic [1:0] GROUP_REGISTER = 2'h0;
	localparam logic [1:0] GROUP_IMMEDIATE = 2'h3;
	localparam logic [6:0] IMM_SEL_FIRST = 7'h02;
	localparam logic [6:0] IMM_SEL_SECOND = 7'h01;
	localparam logic [6:0] IMM_SEL_DOUBLE = 7'h03;
	localparam logic [3:0] CODE_LOAD_INDEX = 4'hD;
	localparam logic [3:0] CODE_LOAD_EXTRA = 4'hE;
	localparam logic [3:0] CODE_LOAD_COND = 4'hF;
	localparam logic [3:0] CODE_STORE_INDEX = 4'h7;
	localparam logic [3:0] CODE_STORE_EXTRA = 4'hB;
	localparam logic [3:0] CODE_MOVE_II = 4'h5;
	localparam logic [3:0] CODE_MOVE_IX = 4'h9;
	localparam logic [3:0] CODE_MOVE_XI = 4'h6;
	localparam logic [3:0] CODE_MOVE_XX = 4'hA;

	// ============================================================
	// Condition loads act on bit 15 alone
	localparam int COND_BIT_POS = 15;
	localparam logic [DATA_W-1:0] COND_BIT_MASK = 16'h8000;
	localparam logic [DATA_W-1:0] ALL_DRIVE = 16'hFFFF;
	localparam logic [DATA_W-1:0] NO_DRIVE = 16'h0000;

	// ============================================================
	// Operation kinds
	typedef enum logic [2:0] {
		XFER_NONE        = 3'b000,
		XFER_LOAD_INDEX  = 3'b001,
		XFER_LOAD_EXTRA  = 3'b010,
		XFER_LOAD_COND   = 3'b011,
		XFER_STORE_INDEX = 3'b100,
		XFER_STORE_EXTRA = 3'b101
	} xfer_type;

	typedef enum logic [2:0] {
		MOVE_NONE = 3'b000,
		MOVE_II   = 3'b001,
		MOVE_IX   = 3'b010,
		MOVE_XI   = 3'b011,
		MOVE_XX   = 3'b100
	} move_type;

	// Load/store code shared by the first and second slots
	function automatic xfer_type code_to_xfer(input logic [3:0] code);
		xfer_type kind;
		kind = XFER_NONE;
		case (code)
			CODE_LOAD_INDEX: kind = XFER_LOAD_INDEX;
			CODE_LOAD_EXTRA: kind = XFER_LOAD_EXTRA;
			CODE_LOAD_COND: kind = XFER_LOAD_COND;
			CODE_STORE_INDEX: kind = XFER_STORE_INDEX;
			CODE_STORE_EXTRA: kind = XFER_STORE_EXTRA;
			default: kind = XFER_NONE;
		endcase
		return kind;
	endfunction

endpackage

// File: rtl/word_decoder.sv
// Combinational decoder of the transfer instruction word
`timescale 1ns/100ps
module word_decoder (
	input  wire logic                              instr_valid,
	input  wire logic [transfer_pkg::WORD_W-1:0]   instr_word,
	output transfer_pkg::xfer_type                 first_op,
	output transfer_pkg::xfer_type                 second_op,
	output transfer_pkg::move_type                 move_op,
	output logic                                   imm_first,
	output logic                                   imm_second,
	output logic                                   cond_req,
	output logic [transfer_pkg::REG_AW-1:0]        src_reg,
	output logic [transfer_pkg::REG_AW-1:0]        second_reg,
	output logic [transfer_pkg::DATA_W-1:0]        imm_data
);
	import transfer_pkg::*;

	logic [WORD_W-1:0] word;
	logic [1:0]        group;
	logic [6:0]        imm_sel;
	logic [3:0]        code_two;

	// Unused bits are forced low before any field is looked at
	assign word = instr_word & USED_MASK; // RULE27
	assign group = word[GROUP_HI:GROUP_LO];
	assign imm_sel = word[SRC_HI:SRC_LO];
	assign code_two = word[SECOND_CODE_HI:SECOND_CODE_LO];
	assign src_reg = word[SRC_HI:SRC_LO];
	assign second_reg = word[SECOND_REG_HI:SECOND_REG_LO];
	assign imm_data = word[IMM_HI:IMM_LO];
	assign cond_req = word[COND_POS];

	// ============================================================
	// Slot decode; an all-zero word (no-operation) decodes to nothing
	always_comb begin
		first_op = XFER_NONE;
		second_op = XFER_NONE;
		move_op = MOVE_NONE;
		imm_first = 1'b0;
		imm_second = 1'b0;
		if (instr_valid && group == GROUP_IMMEDIATE) begin
			imm_first = (imm_sel == IMM_SEL_FIRST) ||
				(imm_sel == IMM_SEL_DOUBLE); // RULE1
			imm_second = (imm_sel == IMM_SEL_SECOND) ||
				(imm_sel == IMM_SEL_DOUBLE); // RULE2
		end else if (instr_valid && group == GROUP_REGISTER) begin
			first_op = code_to_xfer(word[FIRST_CODE_HI:FIRST_CODE_LO]);
			case (code_two)
				CODE_MOVE_II: move_op = MOVE_II;
				CODE_MOVE_IX: move_op = MOVE_IX;
				CODE_MOVE_XI: move_op = MOVE_XI;
				CODE_MOVE_XX: move_op = MOVE_XX;
				default: second_op = code_to_xfer(code_two); // RULE25
			endcase
		end
	end

endmodule

// File: rtl/reg_file.sv
// Flip-flop register file with two reads and two prioritised writes
`timescale 1ns/100ps
module reg_file #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 128,
	parameter int AW    = 7
) (
	input  wire logic             clk_sys,
	input  wire logic             srst,
	input  wire logic [AW-1:0]    rd_addr_a,
	output logic      [WIDTH-1:0] rd_data_a,
	input  wire logic [AW-1:0]    rd_addr_b,
	output logic      [WIDTH-1:0] rd_data_b,
	input  wire logic             wr_en_a,
	input  wire logic [AW-1:0]    wr_addr_a,
	input  wire logic [WIDTH-1:0] wr_data_a,
	input  wire logic             wr_en_b,
	input  wire logic [AW-1:0]    wr_addr_b,
	input  wire logic [WIDTH-1:0] wr_data_b
);
	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] word;
	} file_type;

	file_type file_reg;
	file_type file_next;

	// Reads see the stored value, never the write in flight
	assign rd_data_a = file_reg.word[rd_addr_a];
	assign rd_data_b = file_reg.word[rd_addr_b];

	// ============================================================
	// Both ports write on the same edge; port b is applied after port a, so it wins on a shared address
	always_comb begin
		file_next = file_reg;
		if (wr_en_a) begin
			file_next.word[wr_addr_a] = wr_data_a;
		end
		if (wr_en_b) begin
			file_next.word[wr_addr_b] = wr_data_b;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			file_reg <= '0;
		end else begin
			file_reg <= file_next;
		end
	end

endmodule

// File: rtl/transfer_ops.sv
// Data-transfer instruction execution for the decision processor
`timescale 1ns/100ps
module transfer_ops #(
	parameter int DATA_W = 16,
	parameter int DEPTH  = 128
) (
	input  wire logic                              clk_sys,
	input  wire logic                              srst,
	input  wire logic                              instr_valid,
	input  wire logic [transfer_pkg::WORD_W-1:0]   instr_word,
	input  wire logic [DATA_W-1:0]                 bus_first_in,
	input  wire logic [DATA_W-1:0]                 bus_first_other_oe,
	input  wire logic [DATA_W-1:0]                 bus_second_in,
	input  wire logic [DATA_W-1:0]                 bus_second_other_oe,
	input  wire logic                              compare_strobe,
	input  wire logic [transfer_pkg::REG_AW-1:0]   compare_index,
	output logic      [DATA_W-1:0]                 bus_first_data,
	output logic      [DATA_W-1:0]                 bus_first_oe,
	output logic      [DATA_W-1:0]                 bus_second_data,
	output logic      [DATA_W-1:0]                 bus_second_oe,
	output logic                                   bus_conflict,
	output logic                                   condition_flag,
	output logic                                   exec_active,
	output logic      [transfer_pkg::WORD_W-1:0]   instr_readback
);
	import transfer_pkg::*;

	// ============================================================
	// State of the execution stage
	typedef struct packed {
		logic                 exec_valid;
		logic [DATA_W-1:0]    first_data;
		logic [DATA_W-1:0]    first_oe;
		logic [DATA_W-1:0]    second_data;
		logic [DATA_W-1:0]    second_oe;
		logic                 store_first_index;
		logic                 store_first_extra;
		logic [REG_AW-1:0]    first_dest;
		logic                 store_second_index;
		logic                 store_second_extra;
		logic [REG_AW-1:0]    second_dest;
		logic                 move_to_index;
		logic                 move_to_extra;
		logic [DATA_W-1:0]    move_data;
		logic                 cond_flag;
		logic                 conflict;
		logic [WORD_W-1:0]    readback;
	} state_type;

	state_type state_reg;
	state_type state_next;

	// Decoder outputs
	xfer_type          first_op;
	xfer_type          second_op;
	move_type          move_op;
	logic              imm_first;
	logic              imm_second;
	logic              cond_req;
	logic [REG_AW-1:0] src_reg;
	logic [REG_AW-1:0] second_reg;
	logic [DATA_W-1:0] imm_data;

	// Register file ports
	logic [DATA_W-1:0] index_src_data;
	logic [DATA_W-1:0] index_second_data;
	logic [DATA_W-1:0] extra_src_data;
	logic [DATA_W-1:0] extra_second_data;
	logic [DATA_W-1:0] extra_cmp_data;
	logic              index_wr_a;
	logic              index_wr_b;
	logic [DATA_W-1:0] index_wr_b_data;
	logic              extra_wr_a;
	logic              extra_wr_b;
	logic [DATA_W-1:0] extra_wr_b_data;
	logic [REG_AW-1:0] extra_rd_b_addr;

	// Condition gate and conflict detect
	logic              cond_ok;
	logic              first_clash;
	logic              second_clash;

	// ============================================================
	// Decoder
	word_decoder decode (
		.instr_valid (instr_valid),
		.instr_word  (instr_word),
		.first_op    (first_op),
		.second_op   (second_op),
		.move_op     (move_op),
		.imm_first   (imm_first),
		.imm_second  (imm_second),
		.cond_req    (cond_req),
		.src_reg     (src_reg),
		.second_reg  (second_reg),
		.imm_data    (imm_data)
	);

	// ============================================================
	// Register files: port a first-phase store, port b second or move
	reg_file #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH),
		.AW    (REG_AW)
	) index_file (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.rd_addr_a (src_reg),
		.rd_data_a (index_src_data),
		.rd_addr_b (second_reg),
		.rd_data_b (index_second_data),
		.wr_en_a   (index_wr_a),
		.wr_addr_a (state_reg.first_dest),
		.wr_data_a (bus_first_in),
		.wr_en_b   (index_wr_b),
		.wr_addr_b (state_reg.second_dest),
		.wr_data_b (index_wr_b_data)
	);

	reg_file #(
		.WIDTH (DATA_W),
		.DEPTH (DEPTH),
		.AW    (REG_AW)
	) extra_file (
		.clk_sys   (clk_sys),
		.srst      (srst),
		.rd_addr_a (src_reg),
		.rd_data_a (extra_src_data),
		.rd_addr_b (extra_rd_b_addr),
		.rd_data_b (extra_second_data),
		.wr_en_a   (extra_wr_a),
		.wr_addr_a (state_reg.first_dest),
		.wr_data_a (bus_first_in),
		.wr_en_b   (extra_wr_b),
		.wr_addr_b (state_reg.second_dest),
		.wr_data_b (extra_wr_b_data)
	);

	// Compare shares read port b; never strobed with a second-slot word
	assign extra_rd_b_addr = compare_strobe ? compare_index : second_reg;
	assign extra_cmp_data = extra_second_data;

	// ============================================================
	// Writes land at the end of the execution cycle
	assign index_wr_a = state_reg.exec_valid &&
		state_reg.store_first_index; // RULE10
	assign extra_wr_a = state_reg.exec_valid &&
		state_reg.store_first_extra; // RULE12
	assign index_wr_b = state_reg.exec_valid &&
		(state_reg.store_second_index ||
		state_reg.move_to_index); // RULE11
	assign extra_wr_b = state_reg.exec_valid &&
		(state_reg.store_second_extra ||
		state_reg.move_to_extra); // RULE25
	assign index_wr_b_data = state_reg.move_to_index ?
		state_reg.move_data : bus_second_in; // RULE18
	assign extra_wr_b_data = state_reg.move_to_extra ?
		state_reg.move_data : bus_second_in; // RULE17

	// A conditional word acts only with the flag set
	assign cond_ok = !cond_req || state_reg.cond_flag; // RULE9 RULE13 RULE20

	// Only this unit's own drive can clash; stores and moves never drive
	assign first_clash = |(state_reg.first_oe & bus_first_other_oe);
	assign second_clash = |(state_reg.second_oe & bus_second_other_oe);

	// ============================================================
	// Next-state logic
	always_comb begin
		state_next = state_reg;
		state_next.exec_valid = instr_valid;
		state_next.first_data = '0;
		state_next.first_oe = NO_DRIVE;
		state_next.second_data = '0;
		state_next.second_oe = NO_DRIVE;
		state_next.store_first_index = 1'b0;
		state_next.store_first_extra = 1'b0;
		state_next.store_second_index = 1'b0;
		state_next.store_second_extra = 1'b0;
		state_next.move_to_index = 1'b0;
		state_next.move_to_extra = 1'b0;
		state_next.first_dest = src_reg;
		state_next.second_dest = second_reg;
		state_next.move_data = '0;

		// Clash seen in the execution cycle
		state_next.conflict = state_reg.exec_valid &&
			(first_clash || second_clash); // RULE3 RULE14

		// Immediate data onto either phase
		if (imm_first) begin
			state_next.first_data = imm_data; // RULE1
			state_next.first_oe = ALL_DRIVE;
		end
		if (imm_second) begin
			state_next.second_data = imm_data; // RULE2
			state_next.second_oe = ALL_DRIVE;
		end

		// First-phase slot
		if (cond_ok) begin
			case (first_op)
				XFER_LOAD_INDEX: begin
					state_next.first_data = index_src_data; // RULE7
					state_next.first_oe = ALL_DRIVE;
				end
				XFER_LOAD_EXTRA: begin
					state_next.first_data = extra_src_data; // RULE8
					state_next.first_oe = ALL_DRIVE;
				end
				XFER_STORE_INDEX: state_next.store_first_index = 1'b1;
				XFER_STORE_EXTRA: state_next.store_first_extra = 1'b1;
				default: begin
				end
			endcase
		end
		// Condition loads follow the flag itself, whatever the cond bit
		if (first_op == XFER_LOAD_COND && state_reg.cond_flag) begin
			state_next.first_data = COND_BIT_MASK; // RULE5 RULE26
			state_next.first_oe = COND_BIT_MASK; // RULE4
		end

		// Second-phase slot
		if (cond_ok) begin
			case (second_op)
				XFER_LOAD_INDEX: begin
					state_next.second_data = index_second_data; // RULE25
					state_next.second_oe = ALL_DRIVE;
				end
				XFER_LOAD_EXTRA: begin
					state_next.second_data = extra_second_data; // RULE25
					state_next.second_oe = ALL_DRIVE;
				end
				XFER_STORE_INDEX: state_next.store_second_index = 1'b1;
				XFER_STORE_EXTRA: state_next.store_second_extra = 1'b1;
				default: begin
				end
			endcase
		end
		if (second_op == XFER_LOAD_COND && state_reg.cond_flag) begin
			state_next.second_data = COND_BIT_MASK; // RULE6 RULE26
			state_next.second_oe = COND_BIT_MASK; // RULE4
		end

		// Moves over the private path, source shares the load register
		if (cond_ok) begin
			case (move_op)
				MOVE_II: begin
					state_next.move_data = index_src_data; // RULE16 RULE24
					state_next.move_to_index = 1'b1; // RULE15
				end
				MOVE_IX: begin
					state_next.move_data = index_src_data; // RULE17
					state_next.move_to_extra = 1'b1;
				end
				MOVE_XI: begin
					state_next.move_data = extra_src_data; // RULE18
					state_next.move_to_index = 1'b1;
				end
				MOVE_XX: begin
					state_next.move_data = extra_src_data; // RULE19
					state_next.move_to_extra = 1'b1;
				end
				default: begin
				end
			endcase
		end

		// Flag cleared when the extra register is not below the capture
		if (compare_strobe) begin
			state_next.cond_flag =
				!(extra_cmp_data >= bus_first_in); // RULE23
		end

		// Last word; pause bits pass since pause rides on any word
		if (instr_valid) begin
			state_next.readback = instr_word & USED_MASK; // RULE27 RULE21
		end
	end

	// ============================================================
	// State register; a no-operation word still occupies one cycle
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next; // RULE22
		end
	end

	// ============================================================
	// Outputs
	assign bus_first_data = state_reg.first_data;
	assign bus_first_oe = state_reg.first_oe;
	assign bus_second_data = state_reg.second_data;
	assign bus_second_oe = state_reg.second_oe;
	assign bus_conflict = state_reg.conflict;
	assign condition_flag = state_reg.cond_flag;
	assign exec_active = state_reg.exec_valid;
	assign instr_readback = state_reg.readback;

endmodule

// File: sim/transfer_ops_chk.sv
// Port-level assertions for the transfer unit
`timescale 1ns/100ps
module transfer_ops_chk
	import transfer_pkg::*;
#(
	parameter int DATA_W = 16
) (
	input wire logic                            clk_sys,
	input wire logic                            srst,
	input wire logic                            instr_valid,
	input wire logic [transfer_pkg::WORD_W-1:0] instr_word,
	input wire logic [DATA_W-1:0]               bus_first_other_oe,
	input wire logic [DATA_W-1:0]               bus_second_other_oe,
	input wire logic [DATA_W-1:0]               bus_first_data,
	input wire logic [DATA_W-1:0]               bus_first_oe,
	input wire logic [DATA_W-1:0]               bus_second_data,
	input wire logic [DATA_W-1:0]               bus_second_oe,
	input wire logic                            bus_conflict,
	input wire logic                            condition_flag,
	input wire logic                            exec_active,
	input wire logic [transfer_pkg::WORD_W-1:0] instr_readback
);
	// ============================================================
	// Decode helpers
	default clocking @(posedge clk_sys); endclocking
	default disable iff (srst);
	wire imm = instr_valid && instr_word[31:30] == GROUP_IMMEDIATE;
	wire rg  = instr_valid && instr_word[31:30] == GROUP_REGISTER;
	wire clash = |(bus_first_oe & bus_first_other_oe) ||
		|(bus_second_oe & bus_second_other_oe);
	wire mv = rg && instr_word[15:12] == 4'h0 && instr_word[11:8] inside
		{CODE_MOVE_II, CODE_MOVE_IX, CODE_MOVE_XI, CODE_MOVE_XX};

	// A silent execution cycle followed by no clash report
	sequence quiet_s;
		bus_first_oe == NO_DRIVE && bus_second_oe == NO_DRIVE ##1 !bus_conflict;
	endsequence

	// ============================================================
	// Assertions
	chk_imm_first: assert property (imm && instr_word[22:16] == IMM_SEL_FIRST
		|=> bus_first_oe == ALL_DRIVE && bus_first_data == $past(instr_word[15:0]))
		else $error("first immediate");
	chk_imm_second: assert property (imm && instr_word[22:16] == IMM_SEL_SECOND
		|=> bus_second_oe == ALL_DRIVE && bus_second_data == $past(instr_word[15:0]))
		else $error("second immediate");
	chk_bus_clash: assert property (1'b1 |=> bus_conflict == $past(clash))
		else $error("conflict flag wrong");
	chk_cond_first: assert property (rg && instr_word[15:12] == CODE_LOAD_COND
		|=> bus_first_oe == {$past(condition_flag), 15'h0000}
		&& (bus_first_data[15] || !bus_first_oe[15])) else $error("bit load first");
	chk_cond_second: assert property (rg && instr_word[11:8] == CODE_LOAD_COND
		|=> bus_second_oe == {$past(condition_flag), 15'h0000}
		&& (bus_second_data[15] || !bus_second_oe[15])) else $error("bit load second");
	chk_cond_off: assert property (rg && instr_word[7] && !condition_flag
		|=> quiet_s) else $error("flag clear drive");
	chk_move_quiet: assert property (mv |=> quiet_s)
		else $error("move touched the bus");
	chk_nop_quiet: assert property (instr_valid && instr_word == 32'h0000_0000
		|=> quiet_s) else $error("no-operation acted");
	chk_read_back: assert property (instr_valid |=> exec_active &&
		instr_readback == ($past(instr_word) & USED_MASK)) else $error("readback");
	chk_idle_stands: assert property (!instr_valid |=> !exec_active &&
		bus_first_oe == NO_DRIVE && bus_second_oe == NO_DRIVE) else $error("idle drive");
endmodule

bind transfer_ops transfer_ops_chk #(.DATA_W(DATA_W)) u_transfer_ops_chk (.*);

// File: sim/bus_phase_model.sv
// Other processors sharing one phase of the data bus
`timescale 1ns/100ps
module bus_phase_model (
	input  wire logic        clk_sys,
	input  wire logic [15:0] our_data,
	input  wire logic [15:0] our_oe,
	input  wire logic [15:0] other_en,
	input  wire logic [15:0] other_val,
	output logic      [15:0] bus_level,
	output logic      [15:0] other_oe
);
	// ============================================================
	// Undriven bits wander so a stale value never looks valid
	logic [15:0] idle_reg = 16'hA5A5;
	always @(posedge clk_sys) begin
		idle_reg <= ~idle_reg;
	end
	// Our unit wins a clash here; the clash itself is reported by it
	assign other_oe  = other_en;
	assign bus_level = (our_oe & our_data) | (~our_oe & other_en & other_val) |
		(~our_oe & ~other_en & idle_reg);
endmodule

// File: sim/tb.sv
// Self-checking bench for the transfer unit
`timescale 1ns/100ps
module tb;
	import transfer_pkg::*;
	logic        clk_sys = 1'b0;
	logic        srst = 1'b1;
	logic        instr_valid = 1'b0;
	logic [31:0] instr_word = '0;
	logic        compare_strobe = 1'b0;
	logic [6:0]  compare_index = 7'h00;
	logic [15:0] f_en = '0, f_val = '0;
	logic [15:0] s_en = '0, s_val = '0;
	logic [15:0] bus_first_in, bus_first_other_oe, bus_second_in;
	logic [15:0] bus_second_other_oe, bus_first_data, bus_first_oe;
	logic [15:0] bus_second_data, bus_second_oe, d1, o1, d2, o2;
	logic        bus_conflict, condition_flag, exec_active, cf;
	logic [31:0] instr_readback;
	int          err_total = 0;
	int          total_checks = 0;
	int          i;

	// ============================================================
	// Clock, design and far side
	always #20 clk_sys = ~clk_sys;
	transfer_ops u_transfer_ops (.clk_sys, .srst, .instr_valid, .instr_word,
		.bus_first_in, .bus_first_other_oe, .bus_second_in,
		.bus_second_other_oe, .compare_strobe, .compare_index, .bus_first_data,
		.bus_first_oe, .bus_second_data, .bus_second_oe, .bus_conflict,
		.condition_flag, .exec_active, .instr_readback);
	bus_phase_model u_bus_phase_model_a (.clk_sys, .our_data(bus_first_data),
		.our_oe(bus_first_oe), .other_en(f_en), .other_val(f_val),
		.bus_level(bus_first_in), .other_oe(bus_first_other_oe));
	bus_phase_model u_bus_phase_model_b (.clk_sys, .our_data(bus_second_data),
		.our_oe(bus_second_oe), .other_en(s_en), .other_val(s_val),
		.bus_level(bus_second_in), .other_oe(bus_second_other_oe));

	// ============================================================
	// Shared tasks
	task automatic chk(input logic [79:0] got, input logic [79:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask

	// One word; captures cycle 1 and the clash flag
	task automatic exec(input logic [31:0] w,
		input logic [15:0] fe = '0, fv = '0, se = '0, sv = '0);
		@(posedge clk_sys);
		instr_valid <= 1'b1;
		instr_word <= w;
		f_en <= fe;
		f_val <= fv;
		s_en <= se;
		s_val <= sv;
		@(posedge clk_sys);
		instr_valid <= 1'b0;
		instr_word <= '0;
		#1;
		{d1, o1, d2, o2} = {bus_first_data, bus_first_oe, bus_second_data,
			bus_second_oe};
		@(posedge clk_sys);
		{f_en, s_en} <= '0;
		#1;
		cf = bus_conflict;
	endtask

	task automatic compare(input logic [15:0] v, input logic exp);
		@(posedge clk_sys);
		compare_strobe <= 1'b1;
		compare_index <= 7'h02;
		f_en <= 16'hFFFF;
		f_val <= v;
		@(posedge clk_sys);
		compare_strobe <= 1'b0;
		f_en <= 16'h0000;
		#1;
		chk(condition_flag, exp);
	endtask

	task automatic end_of_test;
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// ============================================================
	// Scenarios
	task automatic t_imm;
		exec(32'hC002_A5C3);
		chk({o1, d1, o2, 15'h0000, cf}, {32'hFFFF_A5C3, 32'h0});
		exec(32'hC001_5A3C, 16'h0000, 16'h0000, 16'h8000, 16'h8000);
		chk({o2, d2, o1, 15'h0000, cf}, {32'hFFFF_5A3C, 32'h1});
		exec(32'hCE02_1111, 16'h0001, 16'h0001, 16'h0000, 16'h0000);
		chk({o1, d1, 15'h0000, cf}, {32'hFFFF_1111, 16'h0001});
	endtask

	task automatic t_ldst;
		logic [31:0] sw[4] = '{32'h0003_7000, 32'h0002_B000, 32'h0000_0705,
			32'h0000_0B09};
		logic [31:0] lw[4] = '{32'h0003_D000, 32'h0002_E000, 32'h0000_0D05,
			32'h0000_0E09};
		logic [15:0] v[4] = '{16'h1234, 16'h00FF, 16'h4321, 16'hBEEF};
		for (i = 0; i < 4; i++) begin
			if (i < 2)
				exec(sw[i], 16'hFFFF, v[i], 16'h0000, v[i]);
			else
				exec(sw[i], 16'h0000, v[i], 16'hFFFF, v[i]);
			chk({o1, o2, 15'h0000, cf}, 48'h0);
			exec(lw[i]);
			chk(i < 2 ? {o1, d1} : {o2, d2}, {16'hFFFF, v[i]});
		end
	endtask

	task automatic t_move;
		logic [31:0] mw[4] = '{32'h0003_050A, 32'h0003_090B, 32'h0009_060C,
			32'h0009_0A0D};
		logic [31:0] lw[4] = '{32'h000A_D000, 32'h000B_E000, 32'h000C_D000,
			32'h000D_E000};
		logic [15:0] v[4] = '{16'h1234, 16'h1234, 16'hBEEF, 16'hBEEF};
		for (i = 0; i < 4; i++) begin
			exec(mw[i], 16'hFFFF, 16'h0F0F, 16'hFFFF, 16'h0F0F);
			chk({o1, o2, 15'h0000, cf}, 48'h0);
			exec(lw[i]);
			chk({o1, d1}, {16'hFFFF, v[i]});
		end
	endtask

	task automatic t_cond(input logic fl, input logic [15:0] mem);
		logic [31:0] cw[4] = '{32'h0000_F080, 32'h0000_F000, 32'h0000_0F80,
			32'h0000_0F00};
		exec(32'h0003_D98F);
		chk({o1, d1 & o1}, {fl ? 16'hFFFF : 16'h0000, fl ? 16'h1234 : 16'h0});
		for (i = 0; i < 4; i++) begin
			exec(cw[i]);
			chk({o1, o2, d1 & o1, d2 & o2}, fl ? (i < 2 ? 64'h8000_0000_8000_0000 :
				64'h0000_8000_0000_8000) : 64'h0);
		end
		exec(32'h0003_7080, 16'hFFFF, 16'h9999);
		exec(32'h0003_058E);
		exec(32'h0003_D000);
		chk(d1, fl ? 16'h9999 : 16'h1234);
		exec(32'h000E_D000);
		chk(d1, mem);
	endtask

	task automatic t_nop;
		exec(32'h0000_0000);
		chk({o1, o2, 15'h0000, cf, instr_readback}, 80'h0);
		exec(32'hFFFF_0000);
		chk({o1, o2, instr_readback}, {32'h0, 32'hCE7F_0000});
	endtask

	// ============================================================
	// Main sequence and hang guard
	initial begin
		repeat (3) @(posedge clk_sys);
		srst <= 1'b0;
		#1;
		chk({bus_first_oe, bus_second_oe, instr_readback}, 64'h0);
		chk({condition_flag, exec_active, bus_conflict}, 32'h0);
		t_imm();
		t_ldst();
		t_move();
		t_cond(1'b0, 16'h0000);
		compare(16'h0100, 1'b1);
		t_cond(1'b1, 16'h9999);
		compare(16'h0010, 1'b0);
		t_nop();
		end_of_test();
	end

	initial begin
		repeat (5000) @(posedge clk_sys);
		err_total++;
		end_of_test();
	end
endmodule
